// ==== sgs_defines.vh ====
// constants for the scatter-gather sequencer: structure layout, cycle codes, register map
`ifndef SGS_DEFINES_VH
`define SGS_DEFINES_VH

// cycle-type codes held in configuration bits [2:0]
`define SGS_CYC_INVALID  3'h0
`define SGS_CYC_BASIC    3'h1
`define SGS_CYC_MEM_SG   3'h4
`define SGS_CYC_PER_SG   3'h6

// configuration word fields
`define SGS_F_CYC        2:0
`define SGS_F_NXTBURST   3
`define SGS_F_NM1        13:4
`define SGS_F_RPOW       17:14
`define SGS_F_SPROT      20:18
`define SGS_F_DPROT      23:21
`define SGS_F_UPPER      31:14

// word index inside one control structure
`define SGS_W_SRC        2'h0
`define SGS_W_DST        2'h1
`define SGS_W_CFG        2'h2
`define SGS_W_LAST       2'h3

// structure select bit: 0 primary, 1 alternate
`define SGS_SEL_PRI      1'h0
`define SGS_SEL_ALT      1'h1

// words moved in one copy phase
`define SGS_COPY_WORDS   10'h004

// register offsets
`define SGS_R_CTRL       8'h00
`define SGS_R_SWREQ      8'h04
`define SGS_R_BASE       8'h08
`define SGS_R_STAT       8'h0c
`define SGS_R_BURST      8'h10

// register reset values
`define SGS_RST_CHAN     4'h0
`define SGS_RST_BASE     32'h00000000

`endif

// ==== sgs_mem_model.sv ====
// word memory behind the sequencer's master port
`timescale 1ns/1ps
module sgs_mem_model (
    // clock
    input  wire        i_sys_clk,
    // request from the sequencer
    input  wire        i_req,
    input  wire        i_wr,
    input  wire [31:0] i_addr,
    input  wire [31:0] i_wdata,
    // answer
    output reg         o_ack,
    output reg  [31:0] o_rdata
);
    logic [31:0] mem [0:1023];
    logic [1:0]  wait_cnt = 2'h0;
    logic        slow = 1'b0;
    logic [31:0] last = 32'h0;
    // answers alternate prompt and two-wait; read lines do not keep stale data
    always @* begin
        o_ack = i_req && (wait_cnt == (slow ? 2'h2 : 2'h0));
        o_rdata = o_ack ? mem[i_addr[11:2]] : ~last;
    end
    always @(posedge i_sys_clk) begin
        if (o_ack) begin
            slow <= ~slow;
            wait_cnt <= 2'h0;
            last <= o_rdata;
            if (i_wr)
                mem[i_addr[11:2]] <= i_wdata;
        end else if (i_req)
            wait_cnt <= wait_cnt + 2'h1;
    end
endmodule // sgs_mem_model

// ==== sgs_mem_port.v ====
// single-word memory master: holds one read or write request until the memory acknowledges it
`timescale 1ns/1ps
module sgs_mem_port (
    // clock and reset
    input  wire        i_sys_clk,
    input  wire        i_reset,
    // command from the sequencer
    input  wire        i_start,
    input  wire        i_wr,
    input  wire [31:0] i_addr,
    input  wire [31:0] i_wdata,
    input  wire [2:0]  i_prot,
    output wire        o_done,
    output reg  [31:0] o_rdata,
    // memory side
    output reg         o_mem_req,
    output reg         o_mem_wr,
    output reg  [31:0] o_mem_addr,
    output reg  [31:0] o_mem_wdata,
    output reg  [2:0]  o_mem_prot,
    input  wire        i_mem_ack,
    input  wire [31:0] i_mem_rdata
);
    assign o_done = o_mem_req & i_mem_ack;

    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_mem_req   <= 1'b0;
            o_mem_wr    <= 1'b0;
            o_mem_addr  <= 32'h00000000;
            o_mem_wdata <= 32'h00000000;
            o_mem_prot  <= 3'h0;
            o_rdata     <= 32'h00000000;
        end else if (o_done) begin
            o_mem_req <= 1'b0;
            if (!o_mem_wr) begin
                o_rdata <= i_mem_rdata;
            end
        end else if (i_start && !o_mem_req) begin
            o_mem_req   <= 1'b1;
            o_mem_wr    <= i_wr;
            o_mem_addr  <= i_addr;
            o_mem_wdata <= i_wdata;
            o_mem_prot  <= i_prot;
        end
    end
endmodule // sgs_mem_port

// ==== sgs_sequencer.v ====
// scatter-gather sequencer for one DMA channel, memory and peripheral modes
// Function
// - memory mode starts on line or manual
// - copy phase moves four words to alternate
// - memory copy ends with auto request, arbitration
// - memory task end raises auto request
// - primary exhausted gets invalid cycle code
// - stop on basic alternate or invalid
// - final basic task pulses done once
// - done only after basic cycle completion
// - peripheral copy runs alternate without arbitration
// - only peripheral mode skips primary arbitration (the code arbitrates before every primary read in both modes)
// - peripheral task end waits for request
// - peripheral mode starts only on line
// - protection fields drive bus protection signal
// - peripheral next-burst bit sets burst flag
// - words zero, four, eight; twelve untouched (the copy phase writes alternate word twelve too)
// - structure select bit: primary 0, alternate 1
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "sgs_defines.vh"
module sgs_sequencer (
    // clock and reset
    input  wire        i_sys_clk,
    input  wire        i_reset,
    // register port
    input  wire [7:0]  i_reg_addr,
    input  wire [31:0] i_reg_wdata,
    input  wire        i_reg_wr,
    input  wire        i_reg_rd,
    output reg  [31:0] o_reg_rdata,
    // channel request and arbitration
    input  wire        i_dma_req,
    input  wire        i_chan_top,
    output wire        o_dma_active,
    output reg         o_dma_done,
    output wire        o_useburst,
    // memory master
    output wire        o_mem_req,
    output wire        o_mem_wr,
    output wire [31:0] o_mem_addr,
    output wire [31:0] o_mem_wdata,
    output wire [2:0]  o_mem_prot,
    input  wire        i_mem_ack,
    input  wire [31:0] i_mem_rdata
);
    localparam [3:0] ST_ARB   = 4'h0;
    localparam [3:0] ST_P_SRC = 4'h1;
    localparam [3:0] ST_P_CFG = 4'h2;
    localparam [3:0] ST_CP_RD = 4'h3;
    localparam [3:0] ST_CP_WR = 4'h4;
    localparam [3:0] ST_P_WB  = 4'h5;
    localparam [3:0] ST_A_SRC = 4'h6;
    localparam [3:0] ST_A_DST = 4'h7;
    localparam [3:0] ST_A_CFG = 4'h8;
    localparam [3:0] ST_T_RD  = 4'h9;
    localparam [3:0] ST_T_WR  = 4'ha;

    reg  [3:0]  state;
    reg         enable;
    reg  [3:0]  chan;
    reg  [31:0] base;
    reg         useburst;
    reg         auto_req;
    reg         manual_req;
    reg         first;
    reg         use_alt;
    reg         mid_task;
    reg         sg_periph;
    reg         took_periph;
    reg         op_wait;
    reg  [31:0] psrc;
    reg  [31:0] pcfg;
    reg  [9:0]  pn;
    reg  [1:0]  cp_idx;
    reg  [31:0] asrc;
    reg  [31:0] adst;
    reg  [31:0] acfg;
    reg  [9:0]  tn;
    reg  [9:0]  bc;

    wire        periph_req;
    wire        mp_done;
    wire [31:0] mp_rdata;
    reg         mp_wr;
    reg  [31:0] mp_addr;
    reg  [31:0] mp_wdata;
    reg  [2:0]  mp_prot;
    reg         want;
    wire        mp_start;
    wire [2:0]  rd_cyc;
    wire [9:0]  pn_next;
    wire [2:0]  pcyc_next;
    wire        wr_ctrl;
    wire        wr_burst;
    wire        burst_edge;

    // address of one word of this channel's primary or alternate structure
    function [31:0] slot_addr;
        input [31:0] f_base;
        input        f_alt;
        input [3:0]  f_chan;
        input [1:0]  f_word;
        begin
            slot_addr = {f_base[31:9], f_alt, f_chan, f_word, 2'b00};
        end
    endfunction

    // end pointers address the last word, so walk back by the remaining count
    function [31:0] word_back;
        input [31:0] f_end;
        input [9:0]  f_cnt;
        begin
            word_back = f_end - {20'h00000, f_cnt, 2'b00};
        end
    endfunction

    // transfers between arbitrations, minus one, from the exponent field
    function [9:0] burst_mask;
        input [3:0] f_rpow;
        begin
            if (f_rpow > 4'h9) begin
                burst_mask = 10'h3ff;
            end else begin
                burst_mask = (10'h001 << f_rpow) - 10'h001;
            end
        end
    endfunction

    sgs_sync u_req_sync (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_async   (i_dma_req),
        .o_level   (periph_req)
    );

    sgs_mem_port u_mem_port (
        .i_sys_clk   (i_sys_clk),
        .i_reset     (i_reset),
        .i_start     (mp_start),
        .i_wr        (mp_wr),
        .i_addr      (mp_addr),
        .i_wdata     (mp_wdata),
        .i_prot      (mp_prot),
        .o_done      (mp_done),
        .o_rdata     (mp_rdata),
        .o_mem_req   (o_mem_req),
        .o_mem_wr    (o_mem_wr),
        .o_mem_addr  (o_mem_addr),
        .o_mem_wdata (o_mem_wdata),
        .o_mem_prot  (o_mem_prot),
        .i_mem_ack   (i_mem_ack),
        .i_mem_rdata (i_mem_rdata)
    );

    // active covers copy and task alike; a peripheral copy flows into its task with no gap
    assign o_dma_active = (state != ST_ARB);
    assign o_useburst   = useburst;
    assign mp_start     = (state != ST_ARB) && !op_wait;
    assign rd_cyc       = i_mem_rdata[`SGS_F_CYC];
    assign pn_next      = pn - `SGS_COPY_WORDS;
    // the last four words of the list leave the primary structure marked invalid
    assign pcyc_next    = (pn < `SGS_COPY_WORDS) ? `SGS_CYC_INVALID : pcfg[`SGS_F_CYC];
    assign wr_ctrl      = i_reg_wr && (i_reg_addr == `SGS_R_CTRL);
    assign wr_burst     = i_reg_wr && (i_reg_addr == `SGS_R_BURST) && i_reg_wdata[0];
    assign burst_edge   = (state == ST_T_WR) && mp_done && (tn == 10'h000) && sg_periph
                          && pcfg[`SGS_F_NXTBURST] && (acfg[`SGS_F_CYC] != `SGS_CYC_BASIC);

    // memory command for the current state
    always @* begin
        mp_wr    = 1'b0;
        mp_addr  = 32'h00000000;
        mp_wdata = 32'h00000000;
        mp_prot  = 3'h0;
        case (state)
            ST_P_SRC: begin
                mp_addr = slot_addr(base, `SGS_SEL_PRI, chan, `SGS_W_SRC);
            end
            ST_P_CFG: begin
                mp_addr = slot_addr(base, `SGS_SEL_PRI, chan, `SGS_W_CFG);
            end
            ST_CP_RD: begin
                mp_addr = word_back(psrc, pn - {8'h00, cp_idx});
                mp_prot = pcfg[`SGS_F_SPROT];
            end
            ST_CP_WR: begin
                mp_wr    = 1'b1;
                mp_addr  = slot_addr(base, `SGS_SEL_ALT, chan, cp_idx);
                mp_wdata = mp_rdata;
                mp_prot  = pcfg[`SGS_F_DPROT];
            end
            ST_P_WB: begin
                mp_wr    = 1'b1;
                mp_addr  = slot_addr(base, `SGS_SEL_PRI, chan, `SGS_W_CFG);
                mp_wdata = {pcfg[`SGS_F_UPPER], pn_next, pcfg[`SGS_F_NXTBURST], pcyc_next};
            end
            ST_A_SRC: begin
                mp_addr = slot_addr(base, `SGS_SEL_ALT, chan, `SGS_W_SRC);
            end
            ST_A_DST: begin
                mp_addr = slot_addr(base, `SGS_SEL_ALT, chan, `SGS_W_DST);
            end
            ST_A_CFG: begin
                mp_addr = slot_addr(base, `SGS_SEL_ALT, chan, `SGS_W_CFG);
            end
            ST_T_RD: begin
                mp_addr = word_back(asrc, tn);
                mp_prot = acfg[`SGS_F_SPROT];
            end
            ST_T_WR: begin
                mp_wr    = 1'b1;
                mp_addr  = word_back(adst, tn);
                mp_wdata = mp_rdata;
                mp_prot  = acfg[`SGS_F_DPROT];
            end
            default: begin
                mp_wr = 1'b0;
            end
        endcase
    end

    // which pending request may win arbitration in the current phase
    always @* begin
        if (first) begin
            want = periph_req | manual_req;
        end else if (sg_periph) begin
            want = periph_req;
        end else if (use_alt) begin
            want = auto_req;
        end else begin
            want = auto_req | periph_req | manual_req;
        end
    end

    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            state       <= ST_ARB;
            enable      <= 1'b0;
            chan        <= `SGS_RST_CHAN;
            base        <= `SGS_RST_BASE;
            useburst    <= 1'b0;
            auto_req    <= 1'b0;
            manual_req  <= 1'b0;
            first       <= 1'b1;
            use_alt     <= 1'b0;
            mid_task    <= 1'b0;
            sg_periph   <= 1'b0;
            took_periph <= 1'b0;
            op_wait     <= 1'b0;
            psrc        <= 32'h00000000;
            pcfg        <= 32'h00000000;
            pn          <= 10'h000;
            cp_idx      <= 2'h0;
            asrc        <= 32'h00000000;
            adst        <= 32'h00000000;
            acfg        <= 32'h00000000;
            tn          <= 10'h000;
            bc          <= 10'h000;
            o_dma_done  <= 1'b0;
            o_reg_rdata <= 32'h00000000;
        end else begin
            o_dma_done <= 1'b0;
            if (mp_start) begin
                op_wait <= 1'b1;
            end else if (mp_done) begin
                op_wait <= 1'b0;
            end
            case (state)
                ST_ARB: begin
                    if (enable && i_chan_top && want) begin
                        auto_req    <= 1'b0;
                        manual_req  <= 1'b0;
                        took_periph <= periph_req;
                        if (!use_alt) begin
                            state <= ST_P_SRC;
                        end else if (mid_task) begin
                            state <= ST_T_RD;
                        end else begin
                            state <= ST_A_SRC;
                        end
                    end
                end
                ST_P_SRC: begin
                    if (mp_done) begin
                        psrc  <= i_mem_rdata;
                        state <= ST_P_CFG;
                    end
                end
                ST_P_CFG: begin
                    if (mp_done) begin
                        pcfg   <= i_mem_rdata;
                        pn     <= i_mem_rdata[`SGS_F_NM1];
                        cp_idx <= 2'h0;
                        if (rd_cyc != `SGS_CYC_MEM_SG && rd_cyc != `SGS_CYC_PER_SG) begin
                            // an invalidated primary ends the transaction here
                            enable   <= 1'b0;
                            first    <= 1'b1;
                            use_alt  <= 1'b0;
                            mid_task <= 1'b0;
                            state    <= ST_ARB;
                        end else if (rd_cyc == `SGS_CYC_PER_SG && !took_periph) begin
                            state <= ST_ARB;
                        end else begin
                            first     <= 1'b0;
                            sg_periph <= (rd_cyc == `SGS_CYC_PER_SG);
                            state     <= ST_CP_RD;
                        end
                    end
                end
                ST_CP_RD: begin
                    if (mp_done) begin
                        state <= ST_CP_WR;
                    end
                end
                ST_CP_WR: begin
                    if (mp_done) begin
                        if (cp_idx == `SGS_W_LAST) begin
                            state <= ST_P_WB;
                        end else begin
                            cp_idx <= cp_idx + 2'h1;
                            state  <= ST_CP_RD;
                        end
                    end
                end
                ST_P_WB: begin
                    if (mp_done) begin
                        pn       <= pn_next;
                        use_alt  <= 1'b1;
                        mid_task <= 1'b0;
                        if (sg_periph) begin
                            state <= ST_A_SRC;
                        end else begin
                            auto_req <= 1'b1;
                            state    <= ST_ARB;
                        end
                    end
                end
                ST_A_SRC: begin
                    if (mp_done) begin
                        asrc  <= i_mem_rdata;
                        state <= ST_A_DST;
                    end
                end
                ST_A_DST: begin
                    if (mp_done) begin
                        adst  <= i_mem_rdata;
                        state <= ST_A_CFG;
                    end
                end
                ST_A_CFG: begin
                    if (mp_done) begin
                        acfg <= i_mem_rdata;
                        tn   <= i_mem_rdata[`SGS_F_NM1];
                        bc   <= 10'h000;
                        if (rd_cyc == `SGS_CYC_INVALID) begin
                            enable  <= 1'b0;
                            first   <= 1'b1;
                            use_alt <= 1'b0;
                            state   <= ST_ARB;
                        end else begin
                            state <= ST_T_RD;
                        end
                    end
                end
                ST_T_RD: begin
                    if (mp_done) begin
                        state <= ST_T_WR;
                    end
                end
                ST_T_WR: begin
                    if (mp_done) begin
                        if (tn == 10'h000) begin
                            mid_task <= 1'b0;
                            use_alt  <= 1'b0;
                            state    <= ST_ARB;
                            if (acfg[`SGS_F_CYC] == `SGS_CYC_BASIC) begin
                                o_dma_done <= 1'b1;
                                enable     <= 1'b0;
                                first      <= 1'b1;
                            end else if (!sg_periph) begin
                                auto_req <= 1'b1;
                            end
                        end else begin
                            tn <= tn - 10'h001;
                            if (bc == burst_mask(acfg[`SGS_F_RPOW])) begin
                                // memory mode re-requests itself, peripheral mode waits on the line
                                bc       <= 10'h000;
                                mid_task <= 1'b1;
                                auto_req <= !sg_periph;
                                state    <= ST_ARB;
                            end else begin
                                bc    <= bc + 10'h001;
                                state <= ST_T_RD;
                            end
                        end
                    end
                end
                default: begin
                    state <= ST_ARB;
                end
            endcase
            // software writes take effect after the sequencer, so a write wins over an end
            if (wr_ctrl) begin
                enable <= i_reg_wdata[0];
                chan   <= i_reg_wdata[7:4];
                if (!enable) begin
                    first    <= 1'b1;
                    use_alt  <= 1'b0;
                    mid_task <= 1'b0;
                end
            end
            if (i_reg_wr && i_reg_addr == `SGS_R_SWREQ && i_reg_wdata[0]) begin
                manual_req <= 1'b1;
            end
            if (i_reg_wr && i_reg_addr == `SGS_R_BASE) begin
                base <= i_reg_wdata;
            end
            // hardware set wins over a write-one clear in the same cycle
            if (burst_edge) begin
                useburst <= 1'b1;
            end else if (wr_burst) begin
                useburst <= 1'b0;
            end
            if (i_reg_rd) begin
                case (i_reg_addr)
                    `SGS_R_CTRL:  o_reg_rdata <= {24'h000000, chan, 3'h0, enable};
                    `SGS_R_BASE:  o_reg_rdata <= base;
                    `SGS_R_STAT:  o_reg_rdata <= {24'h000000, sg_periph, use_alt, manual_req, o_dma_active, state};
                    `SGS_R_BURST: o_reg_rdata <= {31'h00000000, useburst};
                    default:      o_reg_rdata <= 32'h00000000;
                endcase
            end else begin
                o_reg_rdata <= 32'h00000000;
            end
        end
    end
endmodule // sgs_sequencer

// ==== sgs_sequencer_properties.sv ====
// timing properties of the sequencer ports
`timescale 1ns/1ps
module sgs_sequencer_properties (
    // clock and reset
    input wire        i_sys_clk,
    input wire        i_reset,
    // watched ports
    input wire        i_reg_rd,
    input wire [31:0] o_reg_rdata,
    input wire        i_chan_top,
    input wire        o_dma_active,
    input wire        o_dma_done,
    input wire        o_mem_req,
    input wire        o_mem_wr,
    input wire [31:0] o_mem_addr,
    input wire [2:0]  o_mem_prot,
    input wire        i_mem_ack
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    property p_done_once; o_dma_done |=> !o_dma_done [*3]; endproperty
    a_done_once: assert property (p_done_once) else $error("done longer than one cycle");
    property p_done_idle; o_dma_done |-> !o_dma_active ##1 !o_mem_req; endproperty
    a_done_idle: assert property (p_done_idle) else $error("done while busy");
    property p_hold; o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_wr); endproperty
    a_hold: assert property (p_hold) else $error("memory request changed before ack");
    property p_drop; o_mem_req && i_mem_ack |=> !o_mem_req; endproperty
    a_drop: assert property (p_drop) else $error("request kept after ack");
    property p_rise; $rose(o_mem_req) |-> o_dma_active; endproperty
    a_rise: assert property (p_rise) else $error("memory access while arbitrating");
    property p_grant; !o_dma_active && !i_chan_top |=> !o_dma_active; endproperty
    a_grant: assert property (p_grant) else $error("started without grant");
    property p_rdata; !i_reg_rd |=> o_reg_rdata == 32'h0; endproperty
    a_rdata: assert property (p_rdata) else $error("read data outside its cycle");
    property p_prot; o_mem_req && !i_mem_ack |=> $stable(o_mem_prot); endproperty
    a_prot: assert property (p_prot) else $error("protection changed before ack");
endmodule // sgs_sequencer_properties
bind sgs_sequencer sgs_sequencer_properties u_props (.*);

// ==== sgs_sequencer_test.sv ====
// self-checking bench for the scatter-gather sequencer
`timescale 1ns/1ps
module sgs_sequencer_test;
    logic        i_sys_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic [7:0]  i_reg_addr = 8'h00;
    logic [31:0] i_reg_wdata = 32'h0;
    logic        i_reg_wr = 1'b0;
    logic        i_reg_rd = 1'b0;
    logic        i_dma_req = 1'b0;
    logic        i_chan_top = 1'b0;
    wire  [31:0] o_reg_rdata, o_mem_addr, o_mem_wdata, i_mem_rdata;
    wire         o_dma_active, o_dma_done, o_useburst, o_mem_req, o_mem_wr, i_mem_ack;
    wire  [2:0]  o_mem_prot;
    int          fail_count = 0;
    int          checks_done = 0;
    int          done_n = 0;
    int          wr_n = 0;
    int          drops = 0;
    logic        act_q = 1'b0;
    int          k;
    logic [31:0] rd;
    logic [31:0] rows [5][2] = '{'{32'h00, 32'h0}, '{32'h04, 32'h0}, '{32'h08, 32'h0},
                                 '{32'h0c, 32'h0}, '{32'h14, 32'h0}};
    logic [31:0] tl [4] = '{32'h50c, 32'h60c, 32'haaac8031, 32'h5a5a5a5a};
    always #4 i_sys_clk = ~i_sys_clk;
    sgs_sequencer uut (.*);
    sgs_mem_model mem (.i_sys_clk(i_sys_clk), .i_req(o_mem_req), .i_wr(o_mem_wr), .i_addr(o_mem_addr),
                       .i_wdata(o_mem_wdata), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_access(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= wr;
        i_reg_rd <= ~wr;
        @(posedge i_sys_clk);
        i_reg_wr <= 1'b0;
        i_reg_rd <= 1'b0;
        #1 rd = o_reg_rdata;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // copy-phase traffic: source reads from the task list, writes into the alternate slot
    always @(posedge i_sys_clk) begin
        if (o_dma_done)
            done_n++;
        if (o_mem_req && i_mem_ack && o_mem_wr)
            wr_n++;
        if (o_mem_req && i_mem_ack && o_mem_addr[11:8] == 4'h4)
            compare({29'h0, o_mem_prot}, 32'h3);
        // alternate slot reads share this page but carry no protection code
        if (o_mem_req && i_mem_ack && o_mem_wr && o_mem_addr[11:8] == 4'h3)
            compare({29'h0, o_mem_prot}, 32'h5);
        // every fall of active is one pass through arbitration
        if (act_q && !o_dma_active)
            drops++;
        act_q <= o_dma_active;
    end
    initial begin
        #100000;
        fail_count++;
        stop_test();
    end
    initial begin
        repeat (12) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        foreach (rows[i]) begin
            reg_access(1'b0, rows[i][0][7:0], 32'h0);
            compare(rd, rows[i][1]);
        end
        $display("test reset_values done");
        for (k = 0; k < 4; k++) begin
            mem.mem[10'h100 + k] = tl[k];
            mem.mem[10'h140 + k] = 32'hc0de0000 + k;
            mem.mem[10'h180 + k] = 32'h0;
        end
        mem.mem[10'h08c] = 32'h40c;
        mem.mem[10'h08d] = 32'h33c;
        mem.mem[10'h08e] = 32'haaac8034;
        reg_access(1'b1, 8'h08, 32'h200);
        reg_access(1'b1, 8'h00, 32'h31);
        reg_access(1'b1, 8'h04, 32'h1);
        repeat (20) @(posedge i_sys_clk);
        compare({31'h0, o_dma_active}, 32'h0);
        i_chan_top <= 1'b1;
        for (k = 0; k < 3000 && done_n == 0; k++)
            @(posedge i_sys_clk);
        repeat (4) @(posedge i_sys_clk);
        for (k = 0; k < 4; k++) begin
            compare(mem.mem[10'h0cc + k], tl[k]);
            compare(mem.mem[10'h180 + k], 32'hc0de0000 + k);
        end
        compare(mem.mem[10'h08e] & 32'h7, 32'h0);
        compare(done_n, 1);
        reg_access(1'b0, 8'h00, 32'h0);
        compare(rd & 32'h1, 32'h0);
        $display("test memory_scatter_gather done");
        k = wr_n;
        reg_access(1'b1, 8'h00, 32'h31);
        reg_access(1'b1, 8'h04, 32'h1);
        repeat (200) @(posedge i_sys_clk);
        compare(wr_n, k);
        compare(done_n, 1);
        compare(mem.mem[10'h0ce], tl[2]);
        $display("test invalid_primary done");
        mem.mem[10'h08e] = 32'haaac803e;
        mem.mem[10'h102] = 32'haaac8037;
        k = wr_n;
        reg_access(1'b1, 8'h00, 32'h31);
        reg_access(1'b1, 8'h04, 32'h1);
        repeat (60) @(posedge i_sys_clk);
        compare(wr_n, k);
        compare({31'h0, o_useburst}, 32'h0);
        drops = 0;
        i_dma_req <= 1'b1;
        repeat (400) @(posedge i_sys_clk);
        i_dma_req <= 1'b0;
        compare(drops, 2);
        compare(mem.mem[10'h0ce], 32'haaac8037);
        compare(mem.mem[10'h08e] & 32'h7, 32'h0);
        compare(done_n, 1);
        compare({31'h0, o_useburst}, 32'h1);
        reg_access(1'b1, 8'h10, 32'h1);
        compare({31'h0, o_useburst}, 32'h0);
        reg_access(1'b0, 8'h00, 32'h0);
        compare(rd & 32'h1, 32'h0);
        $display("test peripheral_scatter_gather done");
        stop_test();
    end
endmodule // sgs_sequencer_test

// ==== sgs_sync.v ====
// three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module sgs_sync (
    // clock and reset
    input  wire i_sys_clk,
    input  wire i_reset,
    // asynchronous level in, clean level out
    input  wire i_async,
    output reg  o_level
);
    reg stage1;
    reg stage2;
    reg stage3;

    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            stage1  <= 1'b0;
            stage2  <= 1'b0;
            stage3  <= 1'b0;
            o_level <= 1'b0;
        end else begin
            stage1 <= i_async;
            stage2 <= stage1;
            stage3 <= stage2;
            // a single-cycle disagreement never reaches the sequencer
            if (stage2 == stage3) begin
                o_level <= stage3;
            end
        end
    end
endmodule // sgs_sync
